/* rtl/hlsu_defs.vh */
`ifndef HLSU_DEFS_VH
`define HLSU_DEFS_VH
// register byte offsets
`define HLSU_CTRL 8'h00
`define HLSU_INSTR 8'h04
`define HLSU_BASE 8'h08
`define HLSU_INDEX 8'h0C
`define HLSU_SRC 8'h10
`define HLSU_PC 8'h14
`define HLSU_STATUS 8'h18
`define HLSU_RESULT 8'h1C
`define HLSU_NEWBASE 8'h20
`define HLSU_ADDR 8'h24
// control bits
`define HLSU_C_START 0
`define HLSU_C_MSB_FIRST 1
`define HLSU_C_COND 2
`define HLSU_CTRL_RST 32'h00000004
// status bits
`define HLSU_S_BUSY 0
`define HLSU_S_DONE 1
`define HLSU_S_ABORT 2
`define HLSU_S_BASE_WB 3
`define HLSU_S_USER 4
`define HLSU_S_ILLEGAL 5
`define HLSU_S_DEST_WR 6
// instruction fields
`define HLSU_P 24
`define HLSU_U 23
`define HLSU_HIMM 22
`define HLSU_W 21
`define HLSU_L 20
`define HLSU_B 22
`define HLSU_WREG 25
`define HLSU_SGN 6
`define HLSU_HALF 5
// transfer sizes
`define HLSU_SZ_BYTE 2'h0
`define HLSU_SZ_HALF 2'h1
`define HLSU_SZ_WORD 2'h2
// bus cycle types
`define HLSU_CY_IDLE 2'h0
`define HLSU_CY_N 2'h1
`define HLSU_CY_S 2'h2
`define HLSU_CY_I 2'h3
// pipeline offsets of the program counter
`define HLSU_PC_BASE_OFS 32'h00000008
`define HLSU_PC_SRC_OFS 32'h0000000C
`define HLSU_PC_REG 4'hF
`endif

/* rtl/hlsu_unit.v */
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`include "hlsu_defs.vh"
module hlsu_unit (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  input wire wb_we_i,
  input wire [3:0] wb_sel_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg wb_ack_o,
  output reg mem_req_o,
  output reg mem_we_o,
  output reg [31:0] mem_addr_o,
  output reg [31:0] mem_wdata_o,
  output reg [1:0] mem_size_o,
  output reg mem_user_o,
  input wire [31:0] mem_rdata_i,
  input wire mem_ack_i,
  input wire mem_abort_i,
  output reg [1:0] cyc_type_o,
  output reg abort_trap_o,
  output reg done_o
);

  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_WAIT = 2'h2;

  // sequence kinds
  localparam K_LOAD = 2'h0;
  localparam K_LOADPC = 2'h1;
  localparam K_STORE = 2'h2;

  reg [31:0] ctrl;
  reg [31:0] instr;
  reg [31:0] base;
  reg [31:0] index;
  reg [31:0] src;
  reg [31:0] pc;
  reg [31:0] result;
  reg [31:0] newbase;
  reg [31:0] addr_q;
  reg [6:0] status;
  reg [1:0] state;
  reg [2:0] step;
  reg [1:0] kind;
  reg [1:0] size_q;
  reg sgn_q;
  reg wb_q;
  reg user_q;

  // byte-lane merge for partial register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // cycle type of each step; one step per sequence carries the data
  function [1:0] step_type;
    input [1:0] k;
    input [2:0] s;
    begin
      step_type = `HLSU_CY_IDLE;
      case (k)
        K_LOAD: step_type = (s == 3'h0) ? `HLSU_CY_N :
                            (s == 3'h1) ? `HLSU_CY_I : `HLSU_CY_S;
        K_LOADPC: step_type = (s == 3'h0 || s == 3'h2) ? `HLSU_CY_N :
                              (s == 3'h1) ? `HLSU_CY_I : `HLSU_CY_S;
        K_STORE: step_type = `HLSU_CY_N;
        default: step_type = `HLSU_CY_IDLE;
      endcase
    end
  endfunction

  function [2:0] last_step;
    input [1:0] k;
    begin
      case (k)
        K_LOAD: last_step = 3'h2;
        K_LOADPC: last_step = 3'h4;
        default: last_step = 3'h1;
      endcase
    end
  endfunction

  // load lane steering and extension
  function [31:0] fetch_fmt;
    input [31:0] d;
    input [1:0] a;
    input [1:0] sz;
    input sg;
    input msb;
    reg [7:0] b;
    reg [15:0] h;
    reg [63:0] dd;
    begin
      b = msb ? d[(3 - a)*8 +: 8] : d[a*8 +: 8];
      // halfword lanes follow address bit 1 only; bit 0 is not looked at
      h = (a[1] ^ msb) ? d[31:16] : d[15:0];
      dd = {d, d};
      case (sz)
        `HLSU_SZ_BYTE: begin
          fetch_fmt = sg ? {{24{b[7]}}, b} : {24'h000000, b};
        end
        `HLSU_SZ_HALF: begin
          fetch_fmt = sg ? {{16{h[15]}}, h} : {16'h0000, h};
        end
        default: begin
          // unaligned word loads rotate the addressed byte into place
          if (msb) begin
            fetch_fmt = dd[(4 - a)*8 +: 32];
          end else begin
            fetch_fmt = dd[a*8 +: 32];
          end
        end
      endcase
    end
  endfunction

  // instruction decode
  wire [3:0] rn = instr[19:16];
  wire [3:0] rd = instr[15:12];
  wire hw_class = (instr[27:25] == 3'h0) && instr[7] && instr[4] &&
                  (instr[6:5] != 2'h0);
  wire wd_class = (instr[27:26] == 2'h1);
  wire f_p = instr[`HLSU_P];
  wire f_u = instr[`HLSU_U];
  wire f_w = instr[`HLSU_W];
  wire f_l = instr[`HLSU_L];
  wire f_s = instr[`HLSU_SGN];
  wire f_h = instr[`HLSU_HALF];
  // signed stores and unknown classes finish at once with no bus cycle
  wire illegal = !(hw_class || wd_class) || (hw_class && f_s && !f_l);

  // offset choice; register offsets are used unshifted
  wire [31:0] imm8 = {24'h000000, instr[11:8], instr[3:0]};
  wire [31:0] imm12 = {20'h00000, instr[11:0]};
  wire [31:0] offset = hw_class ? (instr[`HLSU_HIMM] ? imm8 : index) :
                       (instr[`HLSU_WREG] ? index : imm12);
  wire [31:0] base_eff = (rn == `HLSU_PC_REG) ? pc + `HLSU_PC_BASE_OFS :
                         base;
  wire [31:0] sum = f_u ? base_eff + offset : base_eff - offset;
  wire [31:0] xfer_addr = f_p ? sum : base_eff;
  wire do_wb = !f_p || f_w;
  wire do_user = wd_class && !f_p && f_w;

  // size: S=0 H=1 unsigned half, S=1 signed byte or half
  wire [1:0] size_d = hw_class ? ((f_s && !f_h) ? `HLSU_SZ_BYTE :
                                  `HLSU_SZ_HALF) :
                      (instr[`HLSU_B] ? `HLSU_SZ_BYTE : `HLSU_SZ_WORD);
  wire sgn_d = hw_class && f_s;
  wire [1:0] kind_d = !f_l ? K_STORE :
                      (rd == `HLSU_PC_REG) ? K_LOADPC : K_LOAD;

  // store data replication
  wire [31:0] st_src = (rd == `HLSU_PC_REG) ? pc + `HLSU_PC_SRC_OFS :
                       src;
  wire [31:0] st_data = (size_d == `HLSU_SZ_HALF) ?
                        {st_src[15:0], st_src[15:0]} :
                        (size_d == `HLSU_SZ_BYTE) ? {4{st_src[7:0]}} : st_src;

  // the ack cycle itself is never taken as a second request
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = bus_req && wb_we_i;
  wire start = bus_wr && (wb_adr_i == `HLSU_CTRL) && wb_sel_i[0] &&
               wb_dat_i[`HLSU_C_START] && (state == ST_IDLE);
  // loads fetch on their first step, stores on their second
  wire data_step = (kind == K_STORE) ? (step == 3'h1) : (step == 3'h0);

  // condition comes from the starting write itself, not the stored copy,
  // so one write can set the condition and launch in the same cycle
  wire cond_new = wb_dat_i[`HLSU_C_COND];

  // wishbone slave: one-cycle registered ack, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      wb_ack_o <= bus_req;
      case (wb_adr_i)
        `HLSU_CTRL: wb_dat_o <= ctrl;
        `HLSU_INSTR: wb_dat_o <= instr;
        `HLSU_BASE: wb_dat_o <= base;
        `HLSU_INDEX: wb_dat_o <= index;
        `HLSU_SRC: wb_dat_o <= src;
        `HLSU_PC: wb_dat_o <= pc;
        `HLSU_STATUS: wb_dat_o <= {25'h0000000, status};
        `HLSU_RESULT: wb_dat_o <= result;
        `HLSU_NEWBASE: wb_dat_o <= newbase;
        `HLSU_ADDR: wb_dat_o <= addr_q;
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // operand registers; writes while busy are ignored to keep inputs stable
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= `HLSU_CTRL_RST;
      instr <= 32'h00000000;
      base <= 32'h00000000;
      index <= 32'h00000000;
      src <= 32'h00000000;
      pc <= 32'h00000000;
    end else if (ce_i && bus_wr && state == ST_IDLE) begin
      case (wb_adr_i)
        `HLSU_CTRL: begin
          ctrl <= merge(ctrl, wb_dat_i, wb_sel_i) &
                  32'h00000006; // start bit self-clears
        end
        `HLSU_INSTR: instr <= merge(instr, wb_dat_i, wb_sel_i);
        `HLSU_BASE: base <= merge(base, wb_dat_i, wb_sel_i);
        `HLSU_INDEX: index <= merge(index, wb_dat_i, wb_sel_i);
        `HLSU_SRC: src <= merge(src, wb_dat_i, wb_sel_i);
        `HLSU_PC: pc <= merge(pc, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // execution sequencer; one step per cycle after the start edge:
  //   load N(data) I S, load into pc N(data) I N S S,
  //   store N N(data) finishing on the answer;
  //   a slow answer stretches the data cycle, so N may show longer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      step <= 3'h0;
      kind <= K_LOAD;
      size_q <= `HLSU_SZ_WORD;
      sgn_q <= 1'b0;
      wb_q <= 1'b0;
      user_q <= 1'b0;
      addr_q <= 32'h00000000;
      newbase <= 32'h00000000;
      result <= 32'h00000000;
      status <= 7'h00;
      mem_req_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= 32'h00000000;
      mem_wdata_o <= 32'h00000000;
      mem_size_o <= `HLSU_SZ_WORD;
      mem_user_o <= 1'b0;
      cyc_type_o <= `HLSU_CY_IDLE;
      abort_trap_o <= 1'b0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      abort_trap_o <= 1'b0;
      done_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          cyc_type_o <= `HLSU_CY_IDLE;
          if (start) begin
            status <= 7'h00;
            if (!cond_new || illegal) begin
              // no effect at all when the condition fails
              status[`HLSU_S_DONE] <= 1'b1;
              status[`HLSU_S_ILLEGAL] <= illegal && cond_new;
              done_o <= 1'b1;
            end else begin
              status[`HLSU_S_BUSY] <= 1'b1;
              kind <= kind_d;
              size_q <= size_d;
              sgn_q <= sgn_d;
              wb_q <= do_wb;
              user_q <= do_user;
              addr_q <= xfer_addr;
              newbase <= sum;
              step <= 3'h0;
              mem_addr_o <= xfer_addr;
              mem_wdata_o <= st_data;
              mem_size_o <= size_d;
              mem_we_o <= !f_l;
              state <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          cyc_type_o <= step_type(kind, step);
          if (data_step) begin
            mem_req_o <= 1'b1;
            mem_user_o <= user_q;
            state <= ST_WAIT;
          end else if (step == last_step(kind)) begin
            status[`HLSU_S_BUSY] <= 1'b0;
            status[`HLSU_S_DONE] <= 1'b1;
            status[`HLSU_S_BASE_WB] <= wb_q;
            status[`HLSU_S_DEST_WR] <= (kind != K_STORE);
            done_o <= 1'b1;
            state <= ST_IDLE;
          end else begin
            step <= step + 3'h1;
          end
        end
        ST_WAIT: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            mem_user_o <= 1'b0;
            if (mem_abort_i) begin
              // nothing is committed so the instruction can be rerun
              status[`HLSU_S_BUSY] <= 1'b0;
              status[`HLSU_S_DONE] <= 1'b1;
              status[`HLSU_S_ABORT] <= 1'b1;
              abort_trap_o <= 1'b1;
              cyc_type_o <= `HLSU_CY_IDLE;
              state <= ST_IDLE;
            end else if (step == last_step(kind)) begin
              // a store ends on its answer; nothing follows the second N
              status[`HLSU_S_BUSY] <= 1'b0;
              status[`HLSU_S_DONE] <= 1'b1;
              status[`HLSU_S_BASE_WB] <= wb_q;
              status[`HLSU_S_USER] <= user_q;
              done_o <= 1'b1;
              state <= ST_IDLE;
            end else begin
              if (kind != K_STORE) begin
                result <= fetch_fmt(mem_rdata_i, addr_q[1:0], size_q, sgn_q,
                                    ctrl[`HLSU_C_MSB_FIRST]);
              end
              status[`HLSU_S_USER] <= user_q;
              step <= step + 3'h1;
              state <= ST_RUN;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // hlsu_unit

/* sim/hlsu_mem_model.sv */
`timescale 1ns/100ps
// memory side: answers after wait_i cycles and may refuse with an abort
module hlsu_mem_model (
  input wire clk_i,
  input wire req_i,
  input wire we_i,
  input wire [31:0] addr_i,
  input wire [31:0] wdata_i,
  input wire [31:0] data_i,
  input wire abort_i,
  input wire [3:0] wait_i,
  output logic ack_o = 1'b0,
  output logic [31:0] rdata_o = 32'h0,
  output logic abort_o = 1'b0,
  output logic [31:0] word_o = 32'h0
);
  logic [3:0] cnt = 4'h0;
  // released data bus flips every cycle so stale data never looks valid
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    abort_o <= 1'b0;
    rdata_o <= ~rdata_o;
    cnt <= (req_i && !ack_o) ? cnt + 4'h1 : 4'h0;
    if (req_i && !ack_o && cnt == wait_i) begin
      ack_o <= 1'b1;
      abort_o <= abort_i;
      rdata_o <= data_i;
      if (we_i && !abort_i) word_o[addr_i[1]*16 +: 16] <= wdata_i[15:0];
    end
  end
endmodule // hlsu_mem_model

/* sim/hlsu_unit_properties.sv */
`timescale 1ns/100ps
module hlsu_unit_properties (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire mem_req_o,
  input wire mem_we_o,
  input wire [31:0] mem_addr_o,
  input wire [31:0] mem_wdata_o,
  input wire [1:0] mem_size_o,
  input wire mem_user_o,
  input wire mem_ack_i,
  input wire mem_abort_i,
  input wire [1:0] cyc_type_o,
  input wire abort_trap_o,
  input wire done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // cycle types: 1 N, 2 S, 3 I
  req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("request dropped early");
  load_seq_a: assert property (
    mem_req_o && mem_ack_i && !mem_we_o && !mem_abort_i |-> ##2 (cyc_type_o == 2'h3)
    ##1 ((cyc_type_o == 2'h1) || ((cyc_type_o == 2'h2) && done_o)))
    else $error("load cycle order wrong");
  store_end_a: assert property (
    mem_req_o && mem_ack_i && mem_we_o && !mem_abort_i |-> ##[1:2] done_o)
    else $error("store not finished");
  abort_trap_a: assert property (
    mem_req_o && mem_ack_i && mem_abort_i |=> abort_trap_o && cyc_type_o == 2'h0)
    else $error("abort not trapped");
  trap_cause_a: assert property (
    abort_trap_o |-> $past(mem_req_o) && $past(mem_ack_i) && $past(mem_abort_i))
    else $error("stray trap");
  half_copy_a: assert property (
    mem_req_o && mem_we_o && mem_size_o == 2'h1 |-> mem_wdata_o[31:16] == mem_wdata_o[15:0])
    else $error("half store not copied");
  user_size_a: assert property (mem_user_o |-> mem_req_o && mem_size_o != 2'h1)
    else $error("user cycle on halfword");
  done_pulse_a: assert property (done_o |=> !done_o) else $error("done too long");
  wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack wrong");
endmodule // hlsu_unit_properties

/* sim/hlsu_unit_tb.sv */
`timescale 1ns/100ps
`include "hlsu_defs.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module hlsu_unit_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, mab = 1'b0, cap_user;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, mdata = 32'h0, stat, cap_wd;
  logic [3:0] wb_sel_i = 4'hF, mwait = 4'h0;
  logic [1:0] cap_size;
  wire [31:0] wb_dat_o, mem_addr_o, mem_wdata_o, mem_rdata_i, word;
  wire [1:0] mem_size_o, cyc_type_o;
  wire wb_ack_o, mem_req_o, mem_we_o, mem_user_o, mem_ack_i, mem_abort_i, abort_trap_o, done_o;
  int fails = 0, total_checks = 0, ndone = 0, ntrap = 0, nreq = 0, nseq = 0, nint = 0;
  hlsu_unit i_dut (.clk_i, .rst_i, .ce_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i, .wb_sel_i,
    .wb_cyc_i, .wb_stb_i, .wb_ack_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o,
    .mem_size_o, .mem_user_o, .mem_rdata_i, .mem_ack_i, .mem_abort_i, .cyc_type_o,
    .abort_trap_o, .done_o);
  hlsu_mem_model i_mem (.clk_i, .req_i(mem_req_o), .we_i(mem_we_o), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .data_i(mdata), .abort_i(mab), .wait_i(mwait), .ack_o(mem_ack_i),
    .rdata_o(mem_rdata_i), .abort_o(mem_abort_i), .word_o(word));
  initial forever #2 clk_i = ~clk_i;
  // pulses are too short to catch from the bus tasks, so tally them here
  always @(posedge clk_i) begin
    if (done_o === 1'b1) ndone++;
    if (abort_trap_o === 1'b1) ntrap++;
    if (cyc_type_o === 2'h2) nseq++;
    if (cyc_type_o === 2'h3) nint++;
    if (mem_req_o === 1'b1 && mem_ack_i === 1'b1) begin
      nreq++;
      cap_user = mem_user_o;
      cap_size = mem_size_o;
      cap_wd = mem_wdata_o;
    end
  end
  task automatic report_and_stop;
    if (fails == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one classic cycle, held until ack is seen at an edge
  task automatic wbx(input [7:0] a, input [31:0] d, input w, output [31:0] q);
    int n;
    n = 0;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i <= w;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin fails++; report_and_stop; end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wbw(input [7:0] a, input [31:0] d);
    logic [31:0] q;
    wbx(a, d, 1'b1, q);
  endtask
  task automatic chkreg(input [7:0] a, input [31:0] e);
    logic [31:0] q;
    wbx(a, 32'h0, 1'b0, q);
    `CHK(q, e)
  endtask
  // load operands, start, wait for done or trap, then fetch status
  task automatic run(input [31:0] ins, b, x, c, rd, input ab, input [3:0] wt);
    int n, d0, t0;
    n = 0;
    d0 = ndone;
    t0 = ntrap;
    mdata <= rd;
    mab <= ab;
    mwait <= wt;
    wbw(`HLSU_INSTR, ins);
    wbw(`HLSU_BASE, b);
    wbw(`HLSU_INDEX, x);
    wbw(`HLSU_SRC, 32'h0000ABCD);
    wbw(`HLSU_PC, 32'h00001000);
    wbw(`HLSU_CTRL, c | 32'h1);
    while (ndone == d0 && ntrap == t0 && n < 100) begin @(posedge clk_i); n++; end
    if (n >= 100) begin fails++; report_and_stop; end
    wbx(`HLSU_STATUS, 32'h0, 1'b0, stat);
  endtask
  task automatic t_regs;
    chkreg(`HLSU_CTRL, `HLSU_CTRL_RST);
    chkreg(8'hF0, 32'h0);
  endtask
  task automatic t_sbyte;
    run(32'hE1F122D3, 32'h100, 32'h0, 32'h4, 32'h80FF7F00, 1'b0, 4'h0);
    chkreg(`HLSU_ADDR, 32'h123);
    chkreg(`HLSU_RESULT, 32'hFFFFFF80);
    chkreg(`HLSU_NEWBASE, 32'h123);
    `CHK(stat[`HLSU_S_BASE_WB], 1'b1)
  endtask
  task automatic t_shalf_be;
    run(32'hE01120F3, 32'h200, 32'h10, 32'h6, 32'h80017FFF, 1'b0, 4'h3);
    chkreg(`HLSU_ADDR, 32'h200);
    chkreg(`HLSU_NEWBASE, 32'h1F0);
    chkreg(`HLSU_RESULT, 32'hFFFF8001);
  endtask
  // condition failing first, then the same load passing
  task automatic t_uhalf;
    int r0, s0, i0;
    r0 = nreq;
    run(32'hE15120B2, 32'h104, 32'h0, 32'h0, 32'hBEEF1234, 1'b0, 4'h1);
    `CHK(nreq, r0)
    s0 = nseq;
    i0 = nint;
    run(32'hE15120B2, 32'h104, 32'h0, 32'h4, 32'hBEEF1234, 1'b0, 4'h1);
    `CHK(nseq - s0, 1)
    `CHK(nint - i0, 1)
    chkreg(`HLSU_ADDR, 32'h102);
    chkreg(`HLSU_RESULT, 32'h0000BEEF);
    `CHK(stat[`HLSU_S_BASE_WB], 1'b0)
  endtask
  task automatic t_store_pc;
    int s0, i0;
    s0 = nseq;
    i0 = nint;
    run(32'hE1CFF0B2, 32'h0, 32'h0, 32'h4, 32'h0, 1'b0, 4'h2);
    `CHK(nseq - s0, 0)
    `CHK(nint - i0, 0)
    `CHK(cap_size, `HLSU_SZ_HALF)
    chkreg(`HLSU_ADDR, 32'h100A);
    `CHK(cap_wd, 32'h100C100C)
    `CHK(word, 32'h100C0000)
  endtask
  task automatic t_user;
    run(32'hE4F12004, 32'h300, 32'h0, 32'h4, 32'h5A5A5AA5, 1'b0, 4'h1);
    chkreg(`HLSU_NEWBASE, 32'h304);
    chkreg(`HLSU_RESULT, 32'hA5);
    `CHK(cap_user, 1'b1)
  endtask
  task automatic t_abort;
    int t0;
    t0 = ntrap;
    run(32'hE15120B2, 32'h104, 32'h0, 32'h4, 32'h0, 1'b1, 4'h1);
    `CHK(ntrap, t0 + 1)
    `CHK(stat[`HLSU_S_ABORT], 1'b1)
  endtask
  // signed byte into the program counter, msb-first lanes, long sequence
  task automatic t_loadpc;
    int s0, i0;
    s0 = nseq;
    i0 = nint;
    run(32'hE1D1F0D5, 32'h400, 32'h0, 32'h6, 32'h12F45678, 1'b0, 4'h0);
    chkreg(`HLSU_ADDR, 32'h405);
    chkreg(`HLSU_RESULT, 32'hFFFFFFF4);
    `CHK(nseq - s0, 2)
    `CHK(nint - i0, 1)
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs;
    t_sbyte;
    t_shalf_be;
    t_uhalf;
    t_store_pc;
    t_user;
    t_abort;
    t_loadpc;
    report_and_stop;
  end
endmodule // hlsu_unit_tb
bind hlsu_unit hlsu_unit_properties i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_size_o, .mem_user_o, .mem_ack_i,
  .mem_abort_i, .cyc_type_o, .abort_trap_o, .done_o);
